/* File: core/dacc_chan_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dacc_chan_if;
	logic enable;
	logic pos_sel;
	logic neg_sel;
	logic oe;
	logic clear_flag;
	logic result;
	logic flag;
	logic pin_out;
	logic pin_oe;

	modport ctrl (
		output enable, pos_sel, neg_sel, oe, clear_flag,
		input  result, flag, pin_out, pin_oe
	);
	modport chan (
		input  enable, pos_sel, neg_sel, oe, clear_flag,
		output result, flag, pin_out, pin_oe
	);
endinterface
`default_nettype wire

/* File: core/dacc_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module dacc_channel (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] pos_first,
	input  wire logic [7:0] pos_second,
	input  wire logic [7:0] ext_ref,
	dacc_chan_if.chan       ch
);
	dacc_pkg::dacc_chan_state_type st;
	dacc_pkg::dacc_chan_state_type next_st;
	logic [7:0] pos_level;
	logic [7:0] neg_level;
	logic       above;

	assign pos_level = ch.pos_sel ? pos_second : pos_first;
	assign neg_level = ch.neg_sel ? dacc_pkg::VREF_CODE : ext_ref;
	assign above     = pos_level > neg_level;
	// pin path bypasses the synchroniser on purpose: fast and unclocked
	assign ch.pin_out = ch.enable & ch.oe & above;
	assign ch.pin_oe  = ch.enable & ch.oe;
	assign ch.result  = st.result;
	assign ch.flag    = st.flag;

	// runs whatever the processor power state is
	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[1:0], ch.enable & above};
		if (!ch.enable) begin
			next_st.result  = 1'b0;
			next_st.flag    = 1'b0;
			next_st.settled = 1'b0;
			next_st.count   = '0;
		end else begin
			// change accepted only once stages two and three agree
			if (st.sync[2] == st.sync[1]) begin
				next_st.result = st.sync[2];
			end
			if (!st.settled) begin
				if (st.count == dacc_pkg::SETTLE_COUNT - 12'h001) begin
					next_st.settled = 1'b1;
				end else begin
					next_st.count = st.count + 12'h001;
				end
			end
			if (ch.clear_flag) begin
				next_st.flag = 1'b0;
			end
			// set after clear, so a same-cycle event wins
			if (st.settled && next_st.result != st.result) begin
				next_st.flag = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_off_forces_zero: assert property (!ch.enable |=> !st.result && !st.flag)
		else $error("result or flag set while disabled");
	chk_change_sets_flag: assert property (
		ch.enable && st.settled && next_st.result != st.result |=> st.flag)
		else $error("flag not set on result change");
	chk_clear_drops_flag: assert property (
		ch.clear_flag && !(st.settled && next_st.result != st.result) |=>
			!st.flag)
		else $error("flag not cleared by software");
	chk_settle_quiet: assert property ($rose(ch.enable) |=> !st.flag [*8])
		else $error("flag set during settling");
	chk_pin_gated: assert property (ch.pin_out |-> ch.enable && ch.oe)
		else $error("pin driven while gated off");
	cov_flag_set: cover property ($rose(st.flag));
endmodule
`default_nettype wire

/* File: core/dacc_pkg.sv */
`default_nettype none
package dacc_pkg;
	// printed offsets are register indices; byte address is index times four
	localparam logic [7:0] CTRL1_INDEX      = 8'hac;
	localparam logic [7:0] CTRL2_INDEX      = 8'had;
	localparam logic [7:0] IRQ_ENABLE_INDEX = 8'hae;
	localparam logic [7:0] IRQ_STATUS_INDEX = 8'haf;
	localparam int         ADDR_WIDTH       = 12;

	localparam int BIT_ENABLE     = 5;
	localparam int BIT_POS_SELECT = 4;
	localparam int BIT_NEG_SELECT = 3;
	localparam int BIT_PIN_OE     = 2;
	localparam int BIT_RESULT     = 1;
	localparam int BIT_FLAG       = 0;
	localparam int BIT_GLOBAL_IRQ = 7;

	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;

	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int SETTLE_TIME_US  = 10;
	localparam int SETTLE_CYCLES   =
		(SETTLE_TIME_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam logic [11:0] SETTLE_COUNT = 12'(SETTLE_CYCLES);

	// analog levels are 8-bit codes; internal reference code is a plain default
	localparam logic [7:0] VREF_CODE = 8'h41;

	typedef struct packed {
		logic [2:0]  sync;
		logic        result;
		logic        flag;
		logic        settled;
		logic [11:0] count;
	} dacc_chan_state_type;

	typedef struct packed {
		logic [1:0]  enable;
		logic [1:0]  pos_sel;
		logic [1:0]  neg_sel;
		logic [1:0]  oe;
		logic [1:0]  irq_en;
		logic        global_en;
		logic        ready;
		logic        slverr;
		logic [31:0] rdata;
		logic        irq;
		logic        wake;
	} dacc_top_state_type;

	function automatic logic [ADDR_WIDTH-1:0] reg_addr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction
endpackage
`default_nettype wire

/* File: core/dacc_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - output one when selected positive level exceeds negative level
// - two independent comparators, identical control register layout
// - enable bit 5 switches the comparator on, clear switches off
// - output and flag unsettled for 10 us after enabling
// - bit 4 picks first or second positive input pin
// - bit 3 picks external reference pin or internal reference
// - bit 2 with enable drives result to pin, unsynchronised
// - bit 1 reads synchronised result, zero while disabled
// - hardware sets change flag on a synchronised result change while enabled and settled
// - flag cleared by writing zero, and while disabled
// - irq only with flag, comparator irq enable and global enable
// - comparators keep running in idle and power-down
// - in power saving an enabled change raises irq and wake
// - both control registers reset to all zeros
module dacc_top (
	input  wire logic            CORE_CLK,
	input  wire logic            RESET_N,
	input  wire logic [11:0]     PADDR,
	input  wire logic            PSEL,
	input  wire logic            PENABLE,
	input  wire logic            PWRITE,
	input  wire logic [31:0]     PWDATA,
	input  wire logic [3:0]      PSTRB,
	output var  logic [31:0]     PRDATA,
	output var  logic            PREADY,
	output var  logic            PSLVERR,
	input  wire logic [1:0][7:0] POS_FIRST,
	input  wire logic [1:0][7:0] POS_SECOND,
	input  wire logic [7:0]      EXT_REF,
	input  wire logic            POWER_SAVE,
	output var  logic [1:0]      CMP_PIN_OUT,
	output var  logic [1:0]      CMP_PIN_OE,
	output var  logic            IRQ,
	output var  logic            WAKE
);
	localparam logic [2:0] SEL_CTRL1  = 3'h0;
	localparam logic [2:0] SEL_CTRL2  = 3'h1;
	localparam logic [2:0] SEL_IRQEN  = 3'h2;
	localparam logic [2:0] SEL_STATUS = 3'h3;
	localparam logic [2:0] SEL_NONE   = 3'h4;

	dacc_pkg::dacc_top_state_type st;
	dacc_pkg::dacc_top_state_type next_st;

	logic [2:0] sel;
	logic       take;
	logic       lane0_write;
	logic [1:0] flag;
	logic [1:0] result;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] clear_flag;
	logic       irq_next;

	function automatic logic [2:0] decode(input logic [11:0] addr);
		if (addr == dacc_pkg::reg_addr(dacc_pkg::CTRL1_INDEX)) begin
			return SEL_CTRL1;
		end else if (addr == dacc_pkg::reg_addr(dacc_pkg::CTRL2_INDEX)) begin
			return SEL_CTRL2;
		end else if (addr == dacc_pkg::reg_addr(dacc_pkg::IRQ_ENABLE_INDEX)) begin
			return SEL_IRQEN;
		end else if (addr == dacc_pkg::reg_addr(dacc_pkg::IRQ_STATUS_INDEX)) begin
			return SEL_STATUS;
		end
		return SEL_NONE;
	endfunction

	function automatic logic [7:0] ctrl_byte(
		input logic en,
		input logic ps,
		input logic ns,
		input logic oe,
		input logic res,
		input logic flg
	);
		logic [7:0] v;
		v = dacc_pkg::CTRL_RESET;
		v[dacc_pkg::BIT_ENABLE]     = en;
		v[dacc_pkg::BIT_POS_SELECT] = ps;
		v[dacc_pkg::BIT_NEG_SELECT] = ns;
		v[dacc_pkg::BIT_PIN_OE]     = oe;
		v[dacc_pkg::BIT_RESULT]     = res;
		v[dacc_pkg::BIT_FLAG]       = flg;
		return v;
	endfunction

	assign sel         = decode(PADDR);
	// a write lands only at the edge where the master sees pready high
	assign take        = PSEL & PENABLE & st.ready;
	assign lane0_write = take & PWRITE & PSTRB[0];

	dacc_chan_if chan_bus [2] ();

	for (genvar i = 0; i < 2; i++) begin : g_chan
		assign chan_bus[i].enable     = st.enable[i];
		assign chan_bus[i].pos_sel    = st.pos_sel[i];
		assign chan_bus[i].neg_sel    = st.neg_sel[i];
		assign chan_bus[i].oe         = st.oe[i];
		assign chan_bus[i].clear_flag = clear_flag[i];
		assign flag[i]                = chan_bus[i].flag;
		assign result[i]              = chan_bus[i].result;
		assign pin_out[i]             = chan_bus[i].pin_out;
		assign pin_oe[i]              = chan_bus[i].pin_oe;

		// flag clears by a zero in the control register or a one in status
		assign clear_flag[i] = lane0_write & (
			(sel == 3'(i) && !PWDATA[dacc_pkg::BIT_FLAG]) ||
			(sel == SEL_STATUS && PWDATA[i]));

		dacc_channel u_chan (
			.clk        (CORE_CLK),
			.rst_n      (RESET_N),
			.pos_first  (POS_FIRST[i]),
			.pos_second (POS_SECOND[i]),
			.ext_ref    (EXT_REF),
			.ch         (chan_bus[i])
		);
	end

	// flag to irq costs one cycle; irq is registered for clean timing
	assign irq_next = st.global_en & |(flag & st.irq_en);

	always_comb begin
		next_st = st;
		next_st.ready  = PSEL & PENABLE & !st.ready;
		next_st.slverr = 1'b0;
		if (PSEL & PENABLE & !st.ready) begin
			next_st.slverr = (sel == SEL_NONE);
			next_st.rdata  = '0;
			if (!PWRITE) begin
				case (sel)
					SEL_CTRL1: begin
						next_st.rdata[7:0] = ctrl_byte(st.enable[0],
							st.pos_sel[0], st.neg_sel[0], st.oe[0],
							result[0], flag[0]);
					end
					SEL_CTRL2: begin
						next_st.rdata[7:0] = ctrl_byte(st.enable[1],
							st.pos_sel[1], st.neg_sel[1], st.oe[1],
							result[1], flag[1]);
					end
					SEL_IRQEN: begin
						next_st.rdata[1:0] = st.irq_en;
						next_st.rdata[dacc_pkg::BIT_GLOBAL_IRQ] = st.global_en;
					end
					SEL_STATUS: begin
						next_st.rdata[1:0] = flag;
					end
					default: begin
						next_st.rdata = '0;
					end
				endcase
			end
		end
		if (lane0_write) begin
			case (sel)
				SEL_CTRL1, SEL_CTRL2: begin
					next_st.enable[sel[0]]  = PWDATA[dacc_pkg::BIT_ENABLE];
					next_st.pos_sel[sel[0]] = PWDATA[dacc_pkg::BIT_POS_SELECT];
					next_st.neg_sel[sel[0]] = PWDATA[dacc_pkg::BIT_NEG_SELECT];
					next_st.oe[sel[0]]      = PWDATA[dacc_pkg::BIT_PIN_OE];
				end
				SEL_IRQEN: begin
					next_st.irq_en    = PWDATA[1:0];
					next_st.global_en = PWDATA[dacc_pkg::BIT_GLOBAL_IRQ];
				end
				default: begin
					next_st.irq_en = st.irq_en;
				end
			endcase
		end
		next_st.irq  = irq_next;
		next_st.wake = irq_next & POWER_SAVE;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign PRDATA      = st.rdata;
	assign PREADY      = st.ready;
	assign PSLVERR     = st.slverr;
	assign IRQ         = st.irq;
	assign WAKE        = st.wake;
	assign CMP_PIN_OUT = pin_out;
	assign CMP_PIN_OE  = pin_oe;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	property p_reset_clears;
		@(posedge CORE_CLK) disable iff (1'b0)
		!RESET_N |=> st.enable == 2'b00 && st.oe == 2'b00 &&
			st.pos_sel == 2'b00 && st.neg_sel == 2'b00 && !IRQ;
	endproperty

	chk_ctrl_reset_zero: assert property (p_reset_clears)
		else $error("control not zero after reset");
	chk_irq_needs_enables: assert property (
		IRQ |-> $past(st.global_en) && |($past(flag) & $past(st.irq_en)))
		else $error("irq without flag and enables");
	chk_irq_follows_flag: assert property (
		st.global_en && (flag & st.irq_en) != 2'b00 |=> IRQ)
		else $error("irq missing for enabled flag");
	chk_enable_write: assert property (
		lane0_write && sel == SEL_CTRL1 |=>
			st.enable[0] == $past(PWDATA[dacc_pkg::BIT_ENABLE]))
		else $error("enable bit not taken");
	chk_wake_power_save: assert property (
		POWER_SAVE && irq_next |=> WAKE && IRQ)
		else $error("no wake in power saving");
	chk_apb_one_wait: assert property (
		PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb answer not after one wait");
	chk_read_disabled_zero: assert property (
		PSEL && PENABLE && !PREADY && !PWRITE && sel == SEL_CTRL2 &&
		!st.enable[1] |=> PRDATA[dacc_pkg::BIT_RESULT] == 1'b0)
		else $error("result reads one while disabled");

	chk_ctrl2_enable_write: assert property (
		lane0_write && sel == SEL_CTRL2 |=>
			st.enable[1] == $past(PWDATA[dacc_pkg::BIT_ENABLE]))
		else $error("second enable bit not taken");

	chk_pos_select_write: assert property (
		lane0_write && sel == SEL_CTRL1 |=>
			st.pos_sel[0] == $past(PWDATA[dacc_pkg::BIT_POS_SELECT]))
		else $error("positive select not taken");

	chk_neg_select_write: assert property (
		lane0_write && sel == SEL_CTRL2 |=>
			st.neg_sel[1] == $past(PWDATA[dacc_pkg::BIT_NEG_SELECT]))
		else $error("negative select not taken");

	chk_pin_oe_write: assert property (
		lane0_write && sel == SEL_CTRL1 |=>
			CMP_PIN_OE[0] == ($past(PWDATA[dacc_pkg::BIT_PIN_OE]) &&
			$past(PWDATA[dacc_pkg::BIT_ENABLE])))
		else $error("pin output enable not taken");

	chk_ctrl2_oe_write: assert property (
		lane0_write && sel == SEL_CTRL2 |=>
			st.oe[1] == $past(PWDATA[dacc_pkg::BIT_PIN_OE]))
		else $error("second pin output enable not taken");

	chk_irq_enable_write: assert property (
		lane0_write && sel == SEL_IRQEN |=>
			st.irq_en == $past(PWDATA[1:0]) &&
			st.global_en == $past(PWDATA[dacc_pkg::BIT_GLOBAL_IRQ]))
		else $error("irq enable not taken");

	// refused writes must leave every control bit alone
	chk_strobe_ignored: assert property (
		take && PWRITE && !PSTRB[0] |=>
			$stable(st.enable) && $stable(st.oe) &&
			$stable(st.pos_sel) && $stable(st.neg_sel) &&
			$stable(st.irq_en) && $stable(st.global_en))
		else $error("write without byte strobe changed state");

	chk_unmapped_no_write: assert property (
		take && sel == SEL_NONE |=>
			$stable(st.enable) && $stable(st.oe) &&
			$stable(st.irq_en) && $stable(st.global_en))
		else $error("unmapped access changed state");

	chk_unmapped_error: assert property (
		PSEL && PENABLE && !PREADY && sel == SEL_NONE |=>
			PREADY && PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");

	chk_mapped_no_error: assert property (
		PSEL && PENABLE && !PREADY && sel != SEL_NONE |=> !PSLVERR)
		else $error("error on mapped register");

	chk_ready_after_access: assert property (
		PREADY |-> $past(PSEL) && $past(PENABLE) && !$past(PREADY))
		else $error("ready without access phase");

	chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("ready held past one cycle");

	chk_write_reads_zero: assert property (
		PSEL && PENABLE && !PREADY && PWRITE |=> PRDATA == 32'h0)
		else $error("read data not zero on write");

	chk_status_read: assert property (
		PSEL && PENABLE && !PREADY && !PWRITE && sel == SEL_STATUS |=>
			PRDATA == {30'h0, $past(flag)})
		else $error("status read differs from flags");

	chk_ctrl1_read: assert property (
		PSEL && PENABLE && !PREADY && !PWRITE && sel == SEL_CTRL1 |=>
			PRDATA[1:0] == {$past(result[0]), $past(flag[0])} &&
			PRDATA[31:6] == 26'h0)
		else $error("first control read differs");

	chk_ctrl2_read_bits: assert property (
		PSEL && PENABLE && !PREADY && !PWRITE && sel == SEL_CTRL2 |=>
			PRDATA[5:2] == {$past(st.enable[1]), $past(st.pos_sel[1]),
			$past(st.neg_sel[1]), $past(st.oe[1])})
		else $error("second control read differs");

	chk_irqen_read: assert property (
		PSEL && PENABLE && !PREADY && !PWRITE && sel == SEL_IRQEN |=>
			PRDATA[1:0] == $past(st.irq_en) && PRDATA[6:2] == 5'h00 &&
			PRDATA[7] == $past(st.global_en))
		else $error("irq enable read differs");

	chk_irq_off_global: assert property (
		!st.global_en |=> !IRQ)
		else $error("irq with global enable off");

	chk_irq_off_masked: assert property (
		(flag & st.irq_en) == 2'b00 |=> !IRQ)
		else $error("irq with every flag masked");

	chk_wake_needs_save: assert property (
		WAKE |-> $past(POWER_SAVE) && IRQ)
		else $error("wake outside power saving");

	chk_no_wake_awake: assert property (
		!POWER_SAVE |=> !WAKE)
		else $error("wake while running");

	chk_reset_quiet_bus: assert property (
		@(posedge CORE_CLK) disable iff (1'b0)
		!RESET_N |=> !PREADY && !PSLVERR && PRDATA == 32'h0 && !WAKE &&
			st.irq_en == 2'b00 && !st.global_en && CMP_PIN_OE == 2'b00)
		else $error("bus or irq state not zero after reset");

	cov_enable_one: cover property (lane0_write && sel == SEL_CTRL1 &&
		PWDATA[dacc_pkg::BIT_ENABLE]);
	cov_irq_raised: cover property ($rose(IRQ));
	cov_wake_raised: cover property ($rose(WAKE));
	cov_unmapped: cover property (PREADY && PSLVERR);
endmodule
`default_nettype wire

/* File: verif/dacc_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
// analog side: level codes move on clock edges only, like a sampled source
module dacc_analog_model (
	input  wire logic            clk,
	input  wire logic [1:0][7:0] want_first,
	input  wire logic [1:0][7:0] want_second,
	input  wire logic [7:0]      want_ref,
	output var  logic [1:0][7:0] pos_first,
	output var  logic [1:0][7:0] pos_second,
	output var  logic [7:0]      ext_ref
);
	initial begin
		pos_first = '0;
		pos_second = '0;
		ext_ref = 8'h00;
	end
	always @(posedge clk) begin
		pos_first <= want_first;
		pos_second <= want_second;
		ext_ref <= want_ref;
	end
endmodule
`default_nettype wire

/* File: verif/dacc_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dacc_top_bench;
	localparam logic [11:0] A_C1 = {2'b00, dacc_pkg::CTRL1_INDEX, 2'b00};
	localparam logic [11:0] A_C2 = {2'b00, dacc_pkg::CTRL2_INDEX, 2'b00};
	localparam logic [11:0] A_IE = {2'b00, dacc_pkg::IRQ_ENABLE_INDEX, 2'b00};
	localparam logic [11:0] A_ST = {2'b00, dacc_pkg::IRQ_STATUS_INDEX, 2'b00};
	logic            core_clk = 1'b0;
	logic            reset_n, psel, penable, pwrite, power_save;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic [3:0]      pstrb;
	logic            pready, pslverr, irq, wake, err;
	logic [1:0]      pin_out, pin_oe;
	logic [1:0][7:0] first_lvl, second_lvl, pos_first, pos_second;
	logic [7:0]      ref_lvl, ext_ref, neg;
	int              num_errors = 0;
	int              samples_checked = 0;
	int              cycles = 0;

	always #2 core_clk = ~core_clk;

	dacc_analog_model i_dacc_analog_model (.clk(core_clk),
		.want_first(first_lvl), .want_second(second_lvl),
		.want_ref(ref_lvl), .pos_first(pos_first),
		.pos_second(pos_second), .ext_ref(ext_ref));
	dacc_top i_dacc_top (.CORE_CLK(core_clk), .RESET_N(reset_n),
		.PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .POS_FIRST(pos_first), .POS_SECOND(pos_second),
		.EXT_REF(ext_ref), .POWER_SAVE(power_save), .CMP_PIN_OUT(pin_out),
		.CMP_PIN_OE(pin_oe), .IRQ(irq), .WAKE(wake));

	task automatic results;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a hang anywhere ends here; tests need about 2700 cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			results();
		end
	end

	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: pins %h expected %h", $time, got, exp);
		end
	endtask

	// pready read as it stood at the rising edge; released at that edge
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic put(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic expect_rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check_reg(rd, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		power_save = 1'b0;
		first_lvl = '0;
		second_lvl = '0;
		ref_lvl = 8'h40;
		idle(20);
		reset_n <= 1'b1;
		expect_rd(A_C1, 32'h0);
		expect_rd(A_C2, 32'h0);
		apb(1'b0, 12'h2c0, 32'h0);
		check_reg({31'h0, err}, 32'h1);
		first_lvl[0] <= 8'h80;
		put(A_C1, 32'h24);
		idle(10);
		check_pin(pin_oe, 2'b01);
		check_pin(pin_out, 2'b01);
		// result follows four cycles after enabling, flag held off while settling
		expect_rd(A_C1, 32'h26);
		put(A_C2, 32'h1c);
		expect_rd(A_C2, 32'h1c);
		check_pin(pin_oe, 2'b01);
		idle(2500);
		pstrb <= 4'he;
		put(A_C1, 32'h00);
		pstrb <= 4'hf;
		expect_rd(A_C1, 32'h26);
		put(A_C1, 32'h24);
		put(A_IE, 32'h81);
		expect_rd(A_IE, 32'h81);
		first_lvl[0] <= 8'h10;
		idle(10);
		check_pin({wake, irq}, 2'b01);
		expect_rd(A_C1, 32'h25);
		expect_rd(A_ST, 32'h1);
		put(A_C1, 32'h24);
		idle(2);
		check_pin({wake, irq}, 2'b00);
		expect_rd(A_C1, 32'h24);
		put(A_IE, 32'h01);
		first_lvl[0] <= 8'h80;
		idle(10);
		check_pin({wake, irq}, 2'b00);
		expect_rd(A_ST, 32'h1);
		put(A_ST, 32'h1);
		expect_rd(A_ST, 32'h0);
		power_save <= 1'b1;
		put(A_IE, 32'h81);
		first_lvl[0] <= 8'h10;
		idle(10);
		check_pin({wake, irq}, 2'b11);
		put(A_C1, 32'h00);
		power_save <= 1'b0;
		expect_rd(A_C1, 32'h0);
		check_pin(pin_oe, 2'b00);
		// comparator 2 alone, every input selection
		first_lvl[1] <= 8'h41;
		second_lvl[1] <= 8'h42;
		ref_lvl <= 8'h30;
		for (int i = 0; i < 4; i++) begin
			put(A_C2, 32'h24 | (32'(i % 2) << 4) | (32'(i / 2) << 3));
			idle(2);
			neg = (i / 2 == 1) ? dacc_pkg::VREF_CODE : 8'h30;
			check_pin(pin_out, {((i % 2 == 1) ? 8'h42 : 8'h41) > neg,
				1'b0});
		end
		results();
	end
endmodule
`default_nettype wire
